/* File: hw/lcdscd_pkg.sv */
package lcdscd_pkg;
  // mode identifiers
  localparam logic [2:0] ID_READ  = 3'h6;
  localparam logic [2:0] ID_WRITE = 3'h5;
  localparam logic [2:0] ID_CMD   = 3'h4;
  // field widths and bit counts
  localparam int ADDR_W   = 6;
  localparam int DATA_W   = 4;
  localparam logic [3:0] ID_LAST   = 4'h2;
  localparam logic [3:0] ADDR_LAST = 4'h5;
  localparam logic [3:0] NIB_LAST  = 4'h3;
  localparam logic [3:0] CMD_LAST  = 4'h8;
  localparam int FIFO_DEPTH = 4;
  // clock sources
  localparam int RC_HZ   = 256000;
  localparam int XTAL_HZ = 32768;
  localparam int EXT_HZ  = 256000;
  localparam logic [2:0] PRE_LAST = 3'(RC_HZ / 32000 - 1);
  localparam int TONE_HI_HZ = 4000;
  localparam int TONE_LO_HZ = 2000;
  localparam logic [2:0] TONE_HI_LAST = 3'(XTAL_HZ / (2 * TONE_HI_HZ) - 1);
  localparam logic [2:0] TONE_LO_LAST = 3'(XTAL_HZ / (2 * TONE_LO_HZ) - 1);
  localparam int TB_W = 15;
  localparam logic [1:0] WD_LAST = 2'h3;
  typedef enum logic [1:0] {
    LCDSCD_SRC_RC   = 2'h0,
    LCDSCD_SRC_XTAL = 2'h1,
    LCDSCD_SRC_EXT  = 2'h3
  } lcdscd_src_t;
  typedef enum logic [2:0] {
    LCDSCD_ST_ID   = 3'h0,
    LCDSCD_ST_ADDR = 3'h1,
    LCDSCD_ST_DATA = 3'h3,
    LCDSCD_ST_CMD  = 3'h2,
    LCDSCD_ST_HALT = 3'h6
  } lcdscd_state_t;
  typedef struct packed {
    logic        osc_on;
    logic        bias_on;
    logic        bias_third;
    logic [1:0]  com_sel;
    lcdscd_src_t src;
    logic        tone_on;
    logic        tone_low;
    logic        irq_en;
    logic        tb_out_en;
    logic        wd_out_en;
    logic [2:0]  rate;
    logic        test_mode;
  } lcdscd_cfg_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } lcdscd_wr_t;
  localparam lcdscd_cfg_t CFG_RST = '{
    osc_on: 1'b0, bias_on: 1'b0, bias_third: 1'b0, com_sel: 2'h0,
    src: LCDSCD_SRC_RC, tone_on: 1'b0, tone_low: 1'b0, irq_en: 1'b0,
    tb_out_en: 1'b0, wd_out_en: 1'b0, rate: 3'h7, test_mode: 1'b0};
endpackage : lcdscd_pkg

/* File: hw/lcdscd_top.sv */
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////
// small fifo between serial writes and the display ram
module lcdscd_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wp_reg;
  logic [PW-1:0]    rp_reg;
  logic [PW:0]      cnt_reg;
  wire              push = in_valid_i & in_ready_o;
  wire              pop  = out_valid_o & out_ready_i;
  assign in_ready_o  = (cnt_reg != (PW+1)'(DEPTH));
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem_reg[rp_reg];
  // storage
  always_ff @(posedge sys_clk_i) begin
    if (push) mem_reg[wp_reg] <= in_data_i;
  end
  // pointers and fill count
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wp_reg  <= '0;
      rp_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) wp_reg <= (wp_reg == PW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
      if (pop) rp_reg <= (rp_reg == PW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
      cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end
endmodule : lcdscd_fifo

////////////////////////////////////////////////////////////////////
// serial command decoder, display ram, time base, watchdog, tone
module lcdscd_top #(
  parameter int ADDR_W = lcdscd_pkg::ADDR_W,
  parameter int DATA_W = lcdscd_pkg::DATA_W
) (
  input  wire logic               sys_clk_i,
  input  wire logic               rst_n_i,
  input  wire logic               cs_n_i,
  input  wire logic               wr_n_i,
  input  wire logic               rd_n_i,
  input  wire logic               data_i,
  output logic                    data_o,
  output logic                    data_oe_o,
  input  wire logic               rc_osc_i,
  input  wire logic               xtal_i,
  input  wire logic               ext_clk_i,
  output logic                    buzzer_out_o,
  output logic                    buzzer_out_n_o,
  output logic                    irq_n_o,
  output logic                    irq_oe_o,
  output lcdscd_pkg::lcdscd_cfg_t cfg_o,
  output logic                    wr_overrun_o
);
  localparam int NP = 7;
  localparam int FW = ADDR_W + DATA_W;

  ////////////////////////////////////////////////////////////////////
  // two-flop synchronisers on every pin input
  logic [NP-1:0] s1_reg;
  logic [NP-1:0] s2_reg;
  logic [NP-1:0] prev_reg;
  wire  [NP-1:0] pins = {ext_clk_i, xtal_i, rc_osc_i, data_i, rd_n_i, wr_n_i, cs_n_i};
  genvar gi;
  generate
    for (gi = 0; gi < NP; gi++) begin : g_sync
      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          s1_reg[gi]   <= 1'b1;
          s2_reg[gi]   <= 1'b1;
          prev_reg[gi] <= 1'b1;
        end else begin
          s1_reg[gi]   <= pins[gi];
          s2_reg[gi]   <= s1_reg[gi];
          prev_reg[gi] <= s2_reg[gi];
        end
      end
    end
  endgenerate
  wire [NP-1:0] rise  = s2_reg & ~prev_reg;
  wire [NP-1:0] fall  = ~s2_reg & prev_reg;
  wire          cs_n  = s2_reg[0];
  wire          din   = s2_reg[3];
  wire          wr_up = rise[1] & ~cs_n;
  wire          rd_dn = fall[2] & ~cs_n;

  ////////////////////////////////////////////////////////////////////
  // serial state
  lcdscd_pkg::lcdscd_state_t st_reg;
  lcdscd_pkg::lcdscd_cfg_t   cfg_reg;
  lcdscd_pkg::lcdscd_cfg_t   cfg_next;
  lcdscd_pkg::lcdscd_wr_t    push_reg;
  lcdscd_pkg::lcdscd_wr_t    pop_data;
  logic [2:0]        id_reg;
  logic [3:0]        cnt_reg;
  logic [1:0]        rbit_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [DATA_W-1:0] nib_reg;
  logic [7:0]        csr_reg;
  logic              cmd_fire_reg;
  logic              push_vld_reg;
  logic              fifo_rdy;
  logic              pop_vld;
  logic [DATA_W-1:0] ram [2**ADDR_W];
  wire [2:0] id_nx  = {id_reg[1:0], din};
  wire       st_id  = (st_reg == lcdscd_pkg::LCDSCD_ST_ID);
  wire       st_adr = (st_reg == lcdscd_pkg::LCDSCD_ST_ADDR);
  wire       st_dat = (st_reg == lcdscd_pkg::LCDSCD_ST_DATA);
  wire       st_cmd = (st_reg == lcdscd_pkg::LCDSCD_ST_CMD);
  wire       m_wr   = (id_reg == lcdscd_pkg::ID_WRITE);
  wire       m_rd   = (id_reg == lcdscd_pkg::ID_READ);
  wire       nib_done = wr_up & st_dat & m_wr & (cnt_reg == lcdscd_pkg::NIB_LAST);
  wire       cmd_done = wr_up & st_cmd & (cnt_reg == lcdscd_pkg::CMD_LAST);
  wire [DATA_W-1:0] rd_nib = ram[addr_reg];

  // mode, address and bit sequencing
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || cs_n) begin
      st_reg   <= lcdscd_pkg::LCDSCD_ST_ID;
      id_reg   <= '0;
      cnt_reg  <= '0;
      addr_reg <= '0;
    end else if (wr_up) begin
      cnt_reg <= cnt_reg + 4'h1;
      unique case (st_reg)
        lcdscd_pkg::LCDSCD_ST_ID: begin
          id_reg <= id_nx;
          if (cnt_reg == lcdscd_pkg::ID_LAST) begin
            cnt_reg <= '0;
            if (id_nx == lcdscd_pkg::ID_CMD) st_reg <= lcdscd_pkg::LCDSCD_ST_CMD;
            else if (id_nx == lcdscd_pkg::ID_READ || id_nx == lcdscd_pkg::ID_WRITE)
              st_reg <= lcdscd_pkg::LCDSCD_ST_ADDR;
            else st_reg <= lcdscd_pkg::LCDSCD_ST_HALT;
          end
        end
        lcdscd_pkg::LCDSCD_ST_ADDR: begin
          addr_reg <= {addr_reg[ADDR_W-2:0], din};
          if (cnt_reg == lcdscd_pkg::ADDR_LAST) begin
            cnt_reg <= '0;
            st_reg  <= lcdscd_pkg::LCDSCD_ST_DATA;
          end
        end
        lcdscd_pkg::LCDSCD_ST_DATA: begin
          if (!m_wr) cnt_reg <= cnt_reg;
          else if (nib_done) begin
            cnt_reg  <= '0;
            addr_reg <= addr_reg + 1'b1;
          end
        end
        lcdscd_pkg::LCDSCD_ST_CMD: begin
          if (cmd_done) cnt_reg <= '0;
        end
        lcdscd_pkg::LCDSCD_ST_HALT: cnt_reg <= cnt_reg;
        default: st_reg <= lcdscd_pkg::LCDSCD_ST_HALT;
      endcase
    end else if (rd_dn && st_dat && m_rd && rbit_reg == 2'h3) begin
      addr_reg <= addr_reg + 1'b1;
    end
  end

  // nibble and command shifters
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      nib_reg <= '0;
      csr_reg <= '0;
    end else if (wr_up) begin
      if (st_dat) nib_reg[cnt_reg[1:0]] <= din;
      if (st_cmd && cnt_reg != lcdscd_pkg::CMD_LAST) csr_reg <= {csr_reg[6:0], din};
    end
  end

  // read data out on read strobe fall, lowest bit first
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || cs_n) begin
      rbit_reg  <= '0;
      data_o    <= 1'b0;
      data_oe_o <= 1'b0;
    end else if (rd_dn && st_dat) begin
      data_o    <= rd_nib[rbit_reg];
      data_oe_o <= 1'b1;
      rbit_reg  <= rbit_reg + 2'h1;
    end else begin
      if (fall[1]) data_oe_o <= 1'b0;  // pin freed before the host drives it
      if (nib_done) rbit_reg <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // write path through the fifo into the ram
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      push_vld_reg <= 1'b0;
      push_reg     <= '0;
      wr_overrun_o <= 1'b0;
    end else begin
      wr_overrun_o <= nib_done & push_vld_reg & ~fifo_rdy;
      if (nib_done) begin
        push_vld_reg <= 1'b1;
        push_reg     <= '{addr: addr_reg, data: {din, nib_reg[2:0]}};
      end else if (fifo_rdy) push_vld_reg <= 1'b0;
    end
  end

  lcdscd_fifo #(
    .WIDTH (FW),
    .DEPTH (lcdscd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push_vld_reg),
    .in_ready_o  (fifo_rdy),
    .in_data_i   (push_reg),
    .out_valid_o (pop_vld),
    .out_ready_i (~rd_dn),
    .out_data_o  (pop_data)
  );

  // ram write port, held off while a read bit is fetched
  always_ff @(posedge sys_clk_i) begin
    if (pop_vld && !rd_dn) ram[pop_data.addr] <= pop_data.data;
  end

  ////////////////////////////////////////////////////////////////////
  // command decode on the eight code bits, ninth ignored
  wire [7:0] c = csr_reg;
  wire cf = cmd_fire_reg;
  wire c_sys   = (c[7:4] == 4'h0);
  wire c_tbclr = cf & (c[7:2] == 6'h03);
  wire c_wdclr = cf & (c[7:1] == 7'h07);
  wire c_src   = cf & (c[7:4] == 4'h1) & (c[3:2] != 2'h0);
  wire c_bias  = cf & (c[7:4] == 4'h2);
  wire c_tone  = cf & (c[7:6] == 2'h1);
  wire c_irq   = cf & (c[7:5] == 3'h4);
  wire c_rate  = cf & (c[7:5] == 3'h5);

  // next configuration
  always_comb begin
    cfg_next = cfg_reg;
    if (cf && c_sys) begin
      unique case (c[3:0])
        4'h0: begin
          cfg_next.osc_on  = 1'b0;
          cfg_next.bias_on = 1'b0;
        end
        4'h1: cfg_next.osc_on    = 1'b1;
        4'h2: cfg_next.bias_on   = 1'b0;
        4'h3: cfg_next.bias_on   = 1'b1;
        4'h4: cfg_next.tb_out_en = 1'b0;
        4'h6: cfg_next.tb_out_en = 1'b1;
        4'h5: cfg_next.wd_out_en = 1'b0;
        4'h7: cfg_next.wd_out_en = 1'b1;
        4'h8: cfg_next.tone_on   = 1'b0;
        4'h9: cfg_next.tone_on   = 1'b1;
        default: cfg_next.tone_on = cfg_reg.tone_on;
      endcase
    end
    if (c_src) cfg_next.src = lcdscd_pkg::lcdscd_src_t'({c[3] & c[2], c[2]});
    if (c_bias) begin
      cfg_next.com_sel    = c[3:2];
      cfg_next.bias_third = c[0];
    end
    if (c_tone) cfg_next.tone_low = c[5];
    if (c_irq) cfg_next.irq_en = c[3];
    if (c_rate) cfg_next.rate = c[2:0];
    if (cf && c == 8'hE0) cfg_next.test_mode = 1'b1;
    if (cf && c == 8'hE3) cfg_next.test_mode = 1'b0;
  end

  // configuration register with power-on defaults
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cfg_reg      <= lcdscd_pkg::CFG_RST;
      cmd_fire_reg <= 1'b0;
    end else begin
      cmd_fire_reg <= cmd_done & ~cs_n;
      cfg_reg      <= cfg_next;
    end
  end
  assign cfg_o = cfg_reg;

  ////////////////////////////////////////////////////////////////////
  // base tick at 32 khz from the selected source
  logic [2:0] pre_reg;
  logic       base_reg;
  wire src_ext = (cfg_reg.src == lcdscd_pkg::LCDSCD_SRC_EXT);
  wire src_x   = (cfg_reg.src == lcdscd_pkg::LCDSCD_SRC_XTAL);
  wire run     = cfg_reg.osc_on | src_ext;  // stop is void on external
  wire src_up  = src_x ? rise[5] : (src_ext ? rise[6] : rise[4]);
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pre_reg  <= '0;
      base_reg <= 1'b0;
    end else begin
      base_reg <= 1'b0;
      if (run && src_up) begin
        pre_reg <= (pre_reg == lcdscd_pkg::PRE_LAST) ? '0 : pre_reg + 3'h1;
        base_reg <= src_x | (pre_reg == lcdscd_pkg::PRE_LAST);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // time base counter and watchdog stage
  logic [lcdscd_pkg::TB_W-1:0] tb_reg;
  logic       tbclk_reg;
  logic [1:0] wd_reg;
  logic       wdf_reg;
  wire [3:0]  tb_sel = 4'(lcdscd_pkg::TB_W - 1) - {1'b0, cfg_reg.rate};
  wire        tb_clk = tb_reg[tb_sel];
  wire        tb_up  = tb_clk & ~tbclk_reg;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || c_tbclr) begin
      tb_reg    <= '0;
      tbclk_reg <= 1'b0;
    end else begin
      tbclk_reg <= tb_clk;
      if (base_reg) tb_reg <= tb_reg + 1'b1;
    end
  end
  // four rising edges of the time base clock make the watchdog time-out
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wd_reg  <= '0;
      wdf_reg <= 1'b0;
    end else begin
      if (c_wdclr) wd_reg <= '0;
      else if (tb_up) wd_reg <= wd_reg + 2'h1;
      if (tb_up && wd_reg == lcdscd_pkg::WD_LAST) wdf_reg <= 1'b1;  // set wins over a clear
      else if (c_wdclr || (c_irq && !c[3])) wdf_reg <= 1'b0;
    end
  end

  // interrupt line, open drain, low while driven
  wire irq_drv = cfg_reg.irq_en &
                 ((cfg_reg.tb_out_en & ~tb_clk) | (cfg_reg.wd_out_en & wdf_reg));
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_oe_o <= 1'b0;
      irq_n_o  <= 1'b1;
    end else begin
      irq_oe_o <= irq_drv;
      irq_n_o  <= ~irq_drv;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // differential tone output
  logic [2:0] tone_reg;
  logic       bz_reg;
  wire [2:0]  tone_last = cfg_reg.tone_low ? lcdscd_pkg::TONE_LO_LAST
                                           : lcdscd_pkg::TONE_HI_LAST;
  wire        tone_act = cfg_reg.tone_on & run;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || !tone_act) begin
      tone_reg <= '0;
      bz_reg   <= 1'b0;
    end else if (base_reg) begin
      tone_reg <= (tone_reg >= tone_last) ? '0 : tone_reg + 3'h1;
      if (tone_reg >= tone_last) bz_reg <= ~bz_reg;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      buzzer_out_o   <= 1'b0;
      buzzer_out_n_o <= 1'b0;
    end else begin
      buzzer_out_o   <= tone_act & bz_reg;
      buzzer_out_n_o <= tone_act & ~bz_reg;
    end
  end
endmodule : lcdscd_top

/* File: sim/lcdscd_host.sv */
`timescale 1ns/1ns
// host side of the serial link: select, strobes and data pin
module lcdscd_host (
  input  wire logic sys_clk_i,
  input  wire logic dev_data_i,
  input  wire logic dev_oe_i,
  output logic      cs_n_o,
  output logic      wr_n_o,
  output logic      rd_n_o,
  output logic      line_o
);
  int   ph = 8;
  logic hd = 1'b0;
  logic hoe = 1'b1;
  logic last = 1'b0;
  // pin nobody drives shows a pattern that changes every cycle
  assign line_o = dev_oe_i ? dev_data_i : (hoe ? hd : ~last);
  always @(posedge sys_clk_i) begin
    last <= line_o;
  end
  // pins idle high
  initial begin
    cs_n_o = 1'b1;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
  end
  // wait n edges, then step just past the edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask : tick
  // one bit, data held across the strobe rise
  task automatic wbit(input logic b);
    hoe = 1'b1;
    hd = b;
    wr_n_o = 1'b0;
    tick(ph);
    wr_n_o = 1'b1;
    tick(ph);
  endtask : wbit
  // select, then mode id msb first
  task automatic open_frame(input logic [2:0] id);
    cs_n_o = 1'b0;
    tick(ph);
    for (int i = 2; i >= 0; i--) wbit(id[i]);
  endtask : open_frame
  task automatic close_frame();
    cs_n_o = 1'b1;
    tick(ph);
  endtask : close_frame
  // address msb first
  task automatic send_addr(input logic [5:0] a);
    for (int i = 5; i >= 0; i--) wbit(a[i]);
  endtask : send_addr
  // command msb first, then the ignored ninth bit
  task automatic send_cmd(input logic [7:0] c, input logic x);
    for (int i = 7; i >= 0; i--) wbit(c[i]);
    wbit(x);
  endtask : send_cmd
  // nibble lsb first
  task automatic wnib(input logic [3:0] d);
    for (int i = 0; i < 4; i++) wbit(d[i]);
  endtask : wnib
  // pin released, one bit taken per read strobe
  task automatic rnib(output logic [3:0] d);
    hoe = 1'b0;
    for (int i = 0; i < 4; i++) begin
      rd_n_o = 1'b0;
      tick(ph);
      d[i] = line_o;
      rd_n_o = 1'b1;
      tick(ph);
    end
  endtask : rnib
endmodule : lcdscd_host

/* File: sim/lcdscd_top_asserts.sv */
`timescale 1ns/1ns
// port-level checks of the serial decoder
module lcdscd_top_asserts (
  input wire logic                    sys_clk_i,
  input wire logic                    rst_n_i,
  input wire logic                    cs_n_i,
  input wire logic                    wr_n_i,
  input wire logic                    rd_n_i,
  input wire logic                    data_oe_o,
  input wire logic                    buzzer_out_o,
  input wire logic                    buzzer_out_n_o,
  input wire logic                    irq_n_o,
  input wire logic                    irq_oe_o,
  input wire lcdscd_pkg::lcdscd_cfg_t cfg_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // settled idle conditions
  sequence s_cs_idle;
    cs_n_i [*5];
  endsequence
  sequence s_tone_quiet;
    (!cfg_o.tone_on || (!cfg_o.osc_on && cfg_o.src != lcdscd_pkg::LCDSCD_SRC_EXT)) [*3];
  endsequence
  // reset, select and strobe relations
  a_reset_cfg_default: assert property (disable iff (1'b0) !rst_n_i |=> cfg_o == lcdscd_pkg::CFG_RST)
    else $error("configuration not at defaults after reset");
  a_cs_idle_quiet: assert property (s_cs_idle |-> !data_oe_o)
    else $error("data pin driven while deselected");
  a_cfg_after_write: assert property ($changed(cfg_o) |-> $past(wr_n_i, 3) && !$past(cs_n_i, 3))
    else $error("configuration changed without a completed write bit");
  a_read_after_fall: assert property ($rose(data_oe_o) |-> !$past(rd_n_i, 2) && !$past(cs_n_i, 2))
    else $error("data pin driven without a read fall");
  a_oe_stands_read: assert property ($fell(data_oe_o) |->
    ($past(wr_n_i, 4) && !$past(wr_n_i, 3)) || $past(cs_n_i))
    else $error("read bit withdrawn before a write strobe fall");
  // tone and flag outputs
  a_tone_quiet_low: assert property (s_tone_quiet |-> !buzzer_out_o && !buzzer_out_n_o)
    else $error("tone outputs active while off");
  a_tone_pair_diff: assert property ($rose(buzzer_out_o) |-> $fell(buzzer_out_n_o))
    else $error("tone outputs not differential");
  a_flag_needs_enable: assert property ((!cfg_o.irq_en) [*3] |-> !irq_oe_o)
    else $error("flag driven while disabled");
  a_flag_drive_low: assert property (irq_oe_o |-> !irq_n_o)
    else $error("flag driven high");
  a_flag_release: assert property ($fell(cfg_o.irq_en) |-> ##[1:3] !irq_oe_o)
    else $error("flag not released after disable");
endmodule : lcdscd_top_asserts

bind lcdscd_top lcdscd_top_asserts u_asserts (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .wr_n_i(wr_n_i),
  .rd_n_i(rd_n_i), .data_oe_o(data_oe_o), .buzzer_out_o(buzzer_out_o),
  .buzzer_out_n_o(buzzer_out_n_o), .irq_n_o(irq_n_o), .irq_oe_o(irq_oe_o), .cfg_o(cfg_o));

/* File: sim/lcdscd_top_tb.sv */
`timescale 1ns/1ns
// decoder bench: command stream, ram access, tone and flag
module lcdscd_top_tb;
  localparam int CEIL  = 60000;
  localparam int RC_NS = 40;
  localparam int XT_NS = 60;
  localparam int EXT_NS = 80;
  // watchdog at 128 hz on the crystal stand-in: three to four periods of 1536 cycles
  localparam int WD_MIN = 4000;
  localparam int WD_MAX = 6200;
  logic                    sys_clk_i = 1'b0;
  logic                    rst_n_i = 1'b0;
  logic                    rc_osc = 1'b0;
  logic                    xtal = 1'b0;
  logic                    ext_clk = 1'b0;
  logic                    ovr;
  logic                    ovr_seen = 1'b0;
  logic                    cs_n, wr_n, rd_n, line;
  logic                    data_o, data_oe_o, bz, bz_n, irq_n, irq_oe;
  logic [3:0]              nib;
  logic [3:0]              pat [3] = '{4'hA, 4'h5, 4'hC};
  lcdscd_pkg::lcdscd_cfg_t cfg_o;
  lcdscd_pkg::lcdscd_cfg_t exp;
  int                      err_total = 0;
  int                      total_checks = 0;
  int                      waited;
  time                     t0;
  // clocks: system, and fast stand-ins for the rc, crystal and external sources
  always #5 sys_clk_i = ~sys_clk_i;
  always #(RC_NS / 2) rc_osc = ~rc_osc;
  always #(XT_NS / 2) xtal = ~xtal;
  always #(EXT_NS / 2) ext_clk = ~ext_clk;
  // any lost nibble is remembered for the end check
  always @(posedge sys_clk_i) begin
    if (ovr === 1'b1) ovr_seen <= 1'b1;
  end
  lcdscd_top DUT (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n), .wr_n_i(wr_n), .rd_n_i(rd_n),
    .data_i(line), .data_o(data_o), .data_oe_o(data_oe_o), .rc_osc_i(rc_osc),
    .xtal_i(xtal), .ext_clk_i(ext_clk), .buzzer_out_o(bz), .buzzer_out_n_o(bz_n),
    .irq_n_o(irq_n), .irq_oe_o(irq_oe), .cfg_o(cfg_o), .wr_overrun_o(ovr));
  lcdscd_host HOST (
    .sys_clk_i(sys_clk_i), .dev_data_i(data_o), .dev_oe_i(data_oe_o), .cs_n_o(cs_n),
    .wr_n_o(wr_n), .rd_n_o(rd_n), .line_o(line));
  // verdict and end of run
  task automatic complete_run();
    if (err_total == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : complete_run
  task automatic check(input logic ok, input string what);
    total_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask : check
  // one command, configuration compared once landed
  task automatic cmd(input logic [7:0] c);
    HOST.send_cmd(c, ~c[0]);
    check(cfg_o === exp, "configuration");
  endtask : cmd
  // tone period counted in periods of the selected source
  task automatic tone(input int hz, input int src_hz, input int src_ns);
    @(posedge bz);
    t0 = $time;
    @(posedge bz);
    check(($time - t0) / src_ns === src_hz / hz, "tone period");
    HOST.tick(1);
    check(bz_n === 1'b0, "tone pair");
  endtask : tone
  // hang guard
  initial begin
    repeat (CEIL) @(posedge sys_clk_i);
    err_total++;
    $display("CHECK FAILED at %0t: timeout", $time);
    complete_run();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk_i);
    #1;
    rst_n_i = 1'b1;
    HOST.tick(4);
    exp = lcdscd_pkg::CFG_RST;
    check(cfg_o === exp, "reset configuration");
    check(irq_oe === 1'b0 && bz === 1'b0 && data_oe_o === 1'b0, "reset pins");
    HOST.open_frame(lcdscd_pkg::ID_CMD);
    exp.osc_on = 1'b1;
    cmd(8'h01);
    exp.bias_on = 1'b1;
    cmd(8'h03);
    exp.bias_on = 1'b0;
    cmd(8'h02);
    exp.tb_out_en = 1'b1;
    cmd(8'h06);
    exp.tb_out_en = 1'b0;
    cmd(8'h04);
    exp.wd_out_en = 1'b1;
    cmd(8'h07);
    exp.wd_out_en = 1'b0;
    cmd(8'h05);
    cmd(8'h0C);
    cmd(8'h0E);
    exp.tone_on = 1'b1;
    cmd(8'h09);
    exp.tone_on = 1'b0;
    cmd(8'h08);
    exp.src = lcdscd_pkg::LCDSCD_SRC_XTAL;
    cmd(8'h14);
    exp.src = lcdscd_pkg::LCDSCD_SRC_EXT;
    cmd(8'h1C);
    exp.src = lcdscd_pkg::LCDSCD_SRC_RC;
    cmd(8'h18);
    cmd(8'h10);
    exp.com_sel = 2'h2;
    exp.bias_third = 1'b1;
    cmd(8'h2B);
    exp.com_sel = 2'h1;
    exp.bias_third = 1'b0;
    cmd(8'h24);
    exp.tone_low = 1'b1;
    cmd(8'h60);
    exp.tone_low = 1'b0;
    cmd(8'h40);
    exp.irq_en = 1'b1;
    cmd(8'h88);
    exp.irq_en = 1'b0;
    cmd(8'h80);
    for (int r = 0; r < 8; r++) begin
      exp.rate = 3'(r);
      cmd({5'h14, exp.rate});
    end
    exp.test_mode = 1'b1;
    cmd(8'hE0);
    exp.test_mode = 1'b0;
    cmd(8'hE3);
    cmd(8'hF0);
    exp.bias_on = 1'b1;
    cmd(8'h03);
    exp.osc_on = 1'b0;
    exp.bias_on = 1'b0;
    cmd(8'h00);
    HOST.close_frame();
    // code cut by deselect, then bits after an unknown id
    HOST.open_frame(lcdscd_pkg::ID_CMD);
    for (int i = 0; i < 8; i++) HOST.wbit(i == 7);
    HOST.close_frame();
    HOST.open_frame(3'h0);
    cmd(8'h01);
    HOST.close_frame();
    // ram: three nibbles with auto increment, slow strobes
    HOST.ph = 12;
    HOST.open_frame(lcdscd_pkg::ID_WRITE);
    HOST.send_addr(6'h3D);
    for (int i = 0; i < 3; i++) HOST.wnib(pat[i]);
    HOST.close_frame();
    HOST.open_frame(lcdscd_pkg::ID_READ);
    HOST.send_addr(6'h3D);
    for (int i = 0; i < 3; i++) begin
      HOST.rnib(nib);
      check(nib === pat[i], "read nibble");
    end
    HOST.close_frame();
    // nibble_rmw_op at 3E, then the next place
    HOST.open_frame(lcdscd_pkg::ID_WRITE);
    HOST.send_addr(6'h3E);
    HOST.rnib(nib);
    check(nib === 4'h5, "modify read");
    HOST.wnib(4'h3);
    HOST.rnib(nib);
    check(nib === 4'hC, "modify next");
    HOST.close_frame();
    HOST.open_frame(lcdscd_pkg::ID_READ);
    HOST.send_addr(6'h3E);
    HOST.rnib(nib);
    check(nib === 4'h3, "modified nibble");
    HOST.close_frame();
    HOST.ph = 8;
    // tone at both pitches, then the time base on the flag pin
    HOST.open_frame(lcdscd_pkg::ID_CMD);
    exp.osc_on = 1'b1;
    cmd(8'h01);
    exp.tone_on = 1'b1;
    cmd(8'h09);
    tone(lcdscd_pkg::TONE_HI_HZ, lcdscd_pkg::RC_HZ, RC_NS);
    exp.tone_low = 1'b1;
    cmd(8'h60);
    tone(lcdscd_pkg::TONE_LO_HZ, lcdscd_pkg::RC_HZ, RC_NS);
    exp.tb_out_en = 1'b1;
    cmd(8'h06);
    exp.irq_en = 1'b1;
    cmd(8'h88);
    for (int i = 0; i < 9000 && irq_oe !== 1'b1; i++) HOST.tick(1);
    check(irq_oe === 1'b1 && irq_n === 1'b0, "flag driven");
    exp.irq_en = 1'b0;
    cmd(8'h80);
    HOST.tick(4);
    check(irq_oe === 1'b0, "flag released");
    // crystal source: tone, then the watchdog flag on the flag pin
    exp.src = lcdscd_pkg::LCDSCD_SRC_XTAL;
    cmd(8'h14);
    tone(lcdscd_pkg::TONE_LO_HZ, lcdscd_pkg::XTAL_HZ, XT_NS);
    exp.tb_out_en = 1'b0;
    cmd(8'h04);
    cmd(8'h0E);
    exp.wd_out_en = 1'b1;
    cmd(8'h07);
    exp.irq_en = 1'b1;
    cmd(8'h88);
    for (waited = 0; waited < 9000 && irq_oe !== 1'b1; waited++) HOST.tick(1);
    check(waited > WD_MIN && waited < WD_MAX && irq_n === 1'b0, "watchdog flag");
    HOST.tick(300);
    check(irq_oe === 1'b1 && irq_n === 1'b0, "flag held");
    cmd(8'h0E);
    check(irq_oe === 1'b0, "flag cleared");
    // external source keeps running after a stop command
    exp.src = lcdscd_pkg::LCDSCD_SRC_EXT;
    cmd(8'h1C);
    exp.osc_on = 1'b0;
    cmd(8'h00);
    tone(lcdscd_pkg::TONE_LO_HZ, lcdscd_pkg::EXT_HZ, EXT_NS);
    exp.tone_on = 1'b0;
    cmd(8'h08);
    check(bz === 1'b0 && bz_n === 1'b0, "tone off");
    check(ovr_seen === 1'b0, "nibble lost");
    HOST.close_frame();
    complete_run();
  end
endmodule : lcdscd_top_tb
